// ==== rtl/ttrx_bit_collector.sv ====
// Purpose: Turns the serial trace bit stream into bytes.
// Assumes: Bits come from logic on the same clock, so no synchroniser.
// Notes:   Inversion and bit order must not change in the middle of a byte.
`timescale 1ns/1ns
`default_nettype none
module ttrx_bit_collector (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          trace_bit,
    input  wire logic          trace_bit_valid,
    input  wire logic          trace_byte_start,
    ttrx_byte_if.collector     bif
);
    typedef struct packed {
        logic [7:0] sh;
        logic [2:0] cnt;
        logic       first;
        logic       raw;
        logic       raw_out;
        logic [7:0] data;
        logic       valid;
        logic       mas;
    } ttrx_col_t;

    ttrx_col_t s_reg;
    ttrx_col_t s_next;

    always_comb begin
        logic       b;
        logic [2:0] c;
        logic [7:0] sh;
        b = trace_bit ^ bif.inv;
        c = trace_byte_start ? 3'h0 : s_reg.cnt;
        sh = bif.rev ? {b, s_reg.sh[7:1]} : {s_reg.sh[6:0], b};
        s_next = s_reg;
        s_next.valid = 1'b0;
        if (trace_bit_valid) begin
            s_next.sh = sh;
            s_next.cnt = c + 3'h1;
            if (c == 3'h0) begin
                s_next.first = b;
                s_next.raw = trace_bit;
            end
            if (c == 3'h7) begin
                s_next.valid = 1'b1;
                s_next.data = sh;
                s_next.mas = s_reg.first;
                s_next.raw_out = s_reg.raw;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bif.data = s_reg.data;
    assign bif.valid = s_reg.valid;
    assign bif.mas = s_reg.mas;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_INVERT: assert property (s_reg.valid |-> s_reg.mas == (s_reg.raw_out ^ bif.inv))
        else $error("Trace bit inversion is wrong.");
    AST_BIT_ORDER: assert property (s_reg.valid |->
        (bif.rev ? s_reg.data[0] : s_reg.data[7]) == s_reg.mas)
        else $error("First received bit landed in the wrong data bit.");
endmodule : ttrx_bit_collector
`default_nettype wire

// ==== rtl/ttrx_byte_if.sv ====
// Purpose: Carries assembled trace bytes and bit handling controls.
// Assumes: One clock domain shared by both ends.
// Notes:   The first bit of each byte travels as the alignment bit.
`timescale 1ns/1ns
`default_nettype none
interface ttrx_byte_if;
    logic [7:0] data;
    logic       valid;
    logic       mas;
    logic       inv;
    logic       rev;
    modport collector (output data, output valid, output mas, input inv, input rev);
    modport framer    (input data, input valid, input mas, output inv, output rev);
endinterface : ttrx_byte_if
`default_nettype wire

// ==== rtl/ttrx_pkg.sv ====
// Purpose: Constants shared by the receive trace identifier block.
// Assumes: Register offsets are per-port byte addresses on a 16-bit port.
// Notes:   Field positions index the 16-bit register words.
package ttrx_pkg;
    localparam logic [7:0] OFS_CONTROL  = 8'hf0;
    localparam logic [7:0] OFS_INDEX    = 8'hf2;
    localparam logic [7:0] OFS_STATUS   = 8'hf4;
    localparam logic [7:0] OFS_LATCHED  = 8'hf6;
    localparam logic [7:0] OFS_IRQ_EN   = 8'hf8;
    localparam logic [7:0] OFS_RX_DATA  = 8'hfc;
    localparam logic [7:0] OFS_EXP_DATA = 8'hfe;
    localparam int CTL_ALIGN_DIS = 3;
    localparam int CTL_CMP_EN    = 2;
    localparam int CTL_INVERT    = 1;
    localparam int CTL_REVERSE   = 0;
    localparam int IDX_EXP_LSB   = 8;
    localparam int IDX_RX_LSB    = 0;
    localparam int ST_MISMATCH   = 2;
    localparam int ST_UNSTABLE   = 1;
    localparam int ST_IDLE       = 0;
    localparam int LT_CHANGE     = 3;
    localparam int ID_BYTES      = 16;
    localparam logic [3:0] LAST_POS       = 4'hf;
    localparam logic [3:0] UNSTABLE_COUNT = 4'h8;
    localparam logic [3:0] IDLE_COUNT     = 4'h5;
    localparam logic [15:0] RESET_WORD    = 16'h0000;
    typedef logic [ID_BYTES-1:0][7:0] ttrx_id_t;
endpackage : ttrx_pkg

// ==== rtl/ttrx_receive.sv ====
// Purpose: Receive trace identifier storage, comparison and status.
// Assumes: Register strobes are one-cycle pulses, never read and write at once.
// Notes:   Read data appears on reg_rdata one clock after reg_rd.
`timescale 1ns/1ns
`default_nettype none
module ttrx_receive (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        port_status_irq_en,
    input  wire logic        trace_bit,
    input  wire logic        trace_bit_valid,
    input  wire logic        trace_byte_start,
    output logic             irq
);
    typedef struct packed {
        logic [3:0]       ctl;
        logic [3:0]       eidx;
        logic [3:0]       ridx;
        logic [3:0]       ien;
        logic [3:0]       latched;
        logic [2:0]       live;
        ttrx_pkg::ttrx_id_t exp;
        ttrx_pkg::ttrx_id_t rx;
        ttrx_pkg::ttrx_id_t cap;
        ttrx_pkg::ttrx_id_t prev;
        logic [3:0]       pos;
        logic             aligned;
        logic             have_prev;
        logic [3:0]       ucnt;
        logic [3:0]       icnt;
        logic [15:0]      rdata;
        logic             irq;
    } ttrx_state_t;

    ttrx_state_t s_reg;
    ttrx_state_t s_next;
    logic [3:0]  set_ev;
    logic [3:0]  clr_ev;

    ttrx_byte_if bif ();

    ttrx_bit_collector u_col (
        .clk              (clk),
        .rst_n            (rst_n),
        .trace_bit        (trace_bit),
        .trace_bit_valid  (trace_bit_valid),
        .trace_byte_start (trace_byte_start),
        .bif              (bif.collector)
    );

    assign bif.inv = s_reg.ctl[ttrx_pkg::CTL_INVERT];
    assign bif.rev = s_reg.ctl[ttrx_pkg::CTL_REVERSE];

    always_comb begin
        logic               ad;
        logic [3:0]         wp;
        logic               take;
        logic               same_rx;
        logic               same_prev;
        ttrx_pkg::ttrx_id_t f;
        ad = s_reg.ctl[ttrx_pkg::CTL_ALIGN_DIS];
        wp = (bif.mas && !ad) ? 4'h0 : s_reg.pos;
        take = ad || bif.mas || s_reg.aligned;
        same_rx = 1'b0;
        same_prev = 1'b0;
        f = s_reg.cap;
        set_ev = 4'h0;
        clr_ev = 4'h0;
        s_next = s_reg;
        if (reg_rd) begin
            case (reg_addr)
                ttrx_pkg::OFS_CONTROL: begin
                    s_next.rdata = {12'h000, s_reg.ctl};
                end
                ttrx_pkg::OFS_INDEX: begin
                    s_next.rdata = {4'h0, s_reg.eidx, 4'h0, s_reg.ridx};
                end
                ttrx_pkg::OFS_STATUS: begin
                    s_next.rdata = {13'h0000, s_reg.live};
                end
                ttrx_pkg::OFS_LATCHED: begin
                    s_next.rdata = {12'h000, s_reg.latched};
                end
                ttrx_pkg::OFS_IRQ_EN: begin
                    s_next.rdata = {12'h000, s_reg.ien};
                end
                ttrx_pkg::OFS_RX_DATA: begin
                    s_next.rdata = {8'h00, s_reg.rx[s_reg.ridx]};
                    s_next.ridx = s_reg.ridx + 4'h1;
                end
                ttrx_pkg::OFS_EXP_DATA: begin
                    s_next.rdata = {8'h00, s_reg.exp[s_reg.eidx]};
                    s_next.eidx = s_reg.eidx + 4'h1;
                end
                default: begin
                    s_next.rdata = ttrx_pkg::RESET_WORD;
                end
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                ttrx_pkg::OFS_CONTROL: begin
                    s_next.ctl = reg_wdata[3:0];
                end
                ttrx_pkg::OFS_INDEX: begin
                    s_next.eidx = reg_wdata[ttrx_pkg::IDX_EXP_LSB +: 4];
                    s_next.ridx = reg_wdata[ttrx_pkg::IDX_RX_LSB +: 4];
                end
                ttrx_pkg::OFS_LATCHED: begin
                    clr_ev = reg_wdata[3:0];
                end
                ttrx_pkg::OFS_IRQ_EN: begin
                    s_next.ien = reg_wdata[3:0];
                end
                ttrx_pkg::OFS_EXP_DATA: begin
                    s_next.exp[s_reg.eidx] = reg_wdata[7:0];
                    s_next.eidx = s_reg.eidx + 4'h1;
                end
                default: begin
                    clr_ev = 4'h0;
                end
            endcase
        end
        if (bif.valid && take) begin
            s_next.cap[wp] = bif.data;
            s_next.pos = wp + 4'h1;
            s_next.aligned = (wp != ttrx_pkg::LAST_POS);
            if (wp == ttrx_pkg::LAST_POS) begin
                f = s_next.cap;
                same_rx = (f == s_reg.rx);
                same_prev = s_reg.have_prev && (f == s_reg.prev);
                s_next.prev = f;
                s_next.have_prev = 1'b1;
                if (same_prev && !same_rx) begin
                    s_next.rx = f;
                    set_ev[ttrx_pkg::LT_CHANGE] = 1'b1;
                end
                if (same_rx || same_prev) begin
                    s_next.ucnt = 4'h0;
                end else if (s_reg.ucnt != ttrx_pkg::UNSTABLE_COUNT) begin
                    s_next.ucnt = s_reg.ucnt + 4'h1;
                end
                if (f != '0) begin
                    s_next.icnt = 4'h0;
                end else if (s_reg.icnt != ttrx_pkg::IDLE_COUNT) begin
                    s_next.icnt = s_reg.icnt + 4'h1;
                end
            end
        end
        s_next.live[ttrx_pkg::ST_UNSTABLE] = (s_next.ucnt == ttrx_pkg::UNSTABLE_COUNT);
        s_next.live[ttrx_pkg::ST_IDLE] = (s_next.icnt == ttrx_pkg::IDLE_COUNT);
        s_next.live[ttrx_pkg::ST_MISMATCH] = s_next.ctl[ttrx_pkg::CTL_CMP_EN]
            && !s_next.ctl[ttrx_pkg::CTL_ALIGN_DIS] && (s_next.rx != s_next.exp);
        set_ev[2:0] = s_next.live & ~s_reg.live;
        // A hardware event in the clearing cycle wins so that it is never lost.
        s_next.latched = (s_reg.latched & ~clr_ev) | set_ev;
        s_next.irq = port_status_irq_en && |(s_next.latched & s_next.ien);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata = s_reg.rdata;
    assign irq = s_reg.irq;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence rx_read_s;
        reg_rd && reg_addr == ttrx_pkg::OFS_RX_DATA;
    endsequence
    sequence exp_access_s;
        (reg_rd || reg_wr) && reg_addr == ttrx_pkg::OFS_EXP_DATA;
    endsequence
    sequence change_clear_s;
        reg_wr && reg_addr == ttrx_pkg::OFS_LATCHED && reg_wdata[ttrx_pkg::LT_CHANGE]
            && !set_ev[ttrx_pkg::LT_CHANGE];
    endsequence

    AST_RX_INDEX: assert property (rx_read_s |=> s_reg.ridx == $past(s_reg.ridx) + 4'h1)
        else $error("Received index did not advance after a data read.");
    AST_EXP_INDEX: assert property (exp_access_s |=> s_reg.eidx == $past(s_reg.eidx) + 4'h1)
        else $error("Expected index did not advance after an access.");
    AST_MISMATCH: assert property (s_reg.live[ttrx_pkg::ST_MISMATCH] == (s_reg.ctl[ttrx_pkg::CTL_CMP_EN]
        && !s_reg.ctl[ttrx_pkg::CTL_ALIGN_DIS] && s_reg.rx != s_reg.exp))
        else $error("Mismatch status disagrees with the identifiers.");
    AST_RISE_LATCH: assert property ($rose(s_reg.live[ttrx_pkg::ST_MISMATCH])
        |-> s_reg.latched[ttrx_pkg::ST_MISMATCH])
        else $error("Mismatch rise was not latched.");
    AST_W1C: assert property (change_clear_s |=> !s_reg.latched[ttrx_pkg::LT_CHANGE])
        else $error("Write of one did not clear the change bit.");
    AST_CHANGE: assert property (set_ev[ttrx_pkg::LT_CHANGE] |=> s_reg.latched[ttrx_pkg::LT_CHANGE]
        && s_reg.rx != $past(s_reg.rx))
        else $error("Identifier update did not raise the change bit.");
    AST_IRQ: assert property (irq == ($past(port_status_irq_en)
        && |(s_reg.latched & s_reg.ien)))
        else $error("Interrupt does not follow the enabled latched bits.");
    AST_IDLE: assert property ($rose(s_reg.live[ttrx_pkg::ST_IDLE])
        |-> $past(s_reg.icnt) == ttrx_pkg::IDLE_COUNT - 4'h1)
        else $error("Idle declared on the wrong count.");
    AST_UNSTABLE: assert property ($rose(s_reg.live[ttrx_pkg::ST_UNSTABLE])
        |-> $past(s_reg.ucnt) == ttrx_pkg::UNSTABLE_COUNT - 4'h1)
        else $error("Unstable declared on the wrong count.");
endmodule : ttrx_receive
`default_nettype wire

// ==== testbench/test_trail_trace_receive.sv ====
// Purpose: Self-checking bench for the receive trace identifier block.
// Assumes: Each register strobe is followed by one idle cycle.
// Notes:   Identifiers are random with the alignment bit forced.
`timescale 1ns/1ns
`default_nettype none
module test_trail_trace_receive;
    logic        clk;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        port_status_irq_en;
    logic        trace_bit;
    logic        trace_bit_valid;
    logic        trace_byte_start;
    logic        irq;
    logic [7:0]  src_byte;
    logic        src_go;
    logic        src_lsb;
    logic        src_inv;
    logic        src_slow;
    logic        src_busy;
    logic [31:0] seed;
    logic [15:0] rdv;
    int          num_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    ttrx_pkg::ttrx_id_t exp_id;
    ttrx_pkg::ttrx_id_t cur_id;
    logic [7:0]  offs [6] = '{8'hf0, 8'hf2, 8'hf4, 8'hf6, 8'hf8, 8'hfa};

    ttrx_receive ttrx_receive_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .port_status_irq_en(port_status_irq_en), .trace_bit(trace_bit),
        .trace_bit_valid(trace_bit_valid), .trace_byte_start(trace_byte_start), .irq(irq));
    ttrx_trace_src ttrx_trace_src_inst (.clk(clk), .rst_n(rst_n), .byte_in(src_byte),
        .go(src_go), .lsb_first(src_lsb), .invert(src_inv), .slow(src_slow),
        .busy(src_busy), .trace_bit(trace_bit), .trace_bit_valid(trace_bit_valid),
        .trace_byte_start(trace_byte_start));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Only byte 0 carries a one in its first bit, so alignment is unambiguous.
    function automatic ttrx_pkg::ttrx_id_t mk_id(input logic lsb);
        ttrx_pkg::ttrx_id_t id;
        logic [31:0] r;
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            id[i] = r[7:0];
            if (lsb) id[i][0] = (i == 0);
            else id[i][7] = (i == 0);
        end
        return id;
    endfunction : mk_id
    task automatic print_verdict();
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rdv = reg_rdata;
        @(posedge clk);
        #1;
    endtask : acc
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk(rdv, e);
    endtask : rc
    task automatic rb(input logic [7:0] a, input int b, input logic e);
        acc(1'b0, a, 16'h0000);
        chk(16'(rdv[b]), 16'(e));
    endtask : rb
    task automatic send_id(input ttrx_pkg::ttrx_id_t id, input int times);
        logic [31:0] r;
        for (int k = 0; k < times; k++) begin
            for (int i = 0; i < 16; i++) begin
                r = rnd();
                src_byte = id[i];
                src_slow = r[0];
                src_go = 1'b1;
                @(posedge clk);
                #1;
                src_go = 1'b0;
                for (int w = 0; w < 40 && src_busy; w++) begin
                    @(posedge clk);
                    #1;
                end
            end
        end
        repeat (4) @(posedge clk);
        #1;
    endtask : send_id

    initial begin
        seed = 32'h0000_cc4b;
        {rst_n, reg_wr, reg_rd, port_status_irq_en, src_go, src_lsb, src_inv} = 7'h00;
        {reg_addr, reg_wdata, src_byte, src_slow} = 33'h0_0000_0000;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        foreach (offs[j]) rc(offs[j], 16'h0000);
        acc(1'b1, 8'hf0, 16'h000f);
        rc(8'hf0, 16'h000f);
        acc(1'b1, 8'hf2, 16'h0f00);
        acc(1'b1, 8'hfe, 16'h00a5);
        rc(8'hf2, 16'h0000);
        exp_id = mk_id(1'b0);
        for (int i = 0; i < 16; i++) acc(1'b1, 8'hfe, {8'h00, exp_id[i]});
        rc(8'hf2, 16'h0000);
        for (int i = 0; i < 16; i++) rc(8'hfe, {8'h00, exp_id[i]});
        for (int m = 0; m < 4; m++) begin
            src_inv = m[0];
            src_lsb = m[1];
            acc(1'b1, 8'hf0, {14'h0000, src_inv, src_lsb});
            cur_id = mk_id(src_lsb);
            send_id(cur_id, 2);
            rb(8'hf6, 3, 1'b1);
            acc(1'b1, 8'hf6, 16'h000f);
            acc(1'b1, 8'hf2, 16'h0000);
            for (int i = 0; i < 16; i++) rc(8'hfc, {8'h00, cur_id[i]});
            rc(8'hf2, 16'h0000);
        end
        acc(1'b1, 8'hf0, 16'h0007);
        send_id(cur_id, 1);
        rb(8'hf4, 2, 1'b1);
        rb(8'hf6, 2, 1'b1);
        port_status_irq_en = 1'b1;
        acc(1'b1, 8'hf8, 16'h0008);
        chk(16'(irq), 16'h0000);
        acc(1'b1, 8'hf8, 16'h0004);
        chk(16'(irq), 16'h0001);
        port_status_irq_en = 1'b0;
        acc(1'b1, 8'hf6, 16'h0000);
        chk(16'(irq), 16'h0000);
        rb(8'hf6, 2, 1'b1);
        acc(1'b1, 8'hf6, 16'h0004);
        rb(8'hf6, 2, 1'b0);
        acc(1'b1, 8'hf2, 16'h0000);
        for (int i = 0; i < 16; i++) acc(1'b1, 8'hfe, {8'h00, cur_id[i]});
        send_id(cur_id, 1);
        rb(8'hf4, 2, 1'b0);
        acc(1'b1, 8'hf6, 16'h000f);
        for (int k = 0; k < 8; k++) begin
            rb(8'hf4, 1, 1'b0);
            send_id(mk_id(1'b1), 1);
        end
        rb(8'hf4, 1, 1'b1);
        rb(8'hf6, 3, 1'b0);
        rb(8'hf6, 1, 1'b1);
        // A zero identifier has no alignment bit, so it is stored unaligned.
        acc(1'b1, 8'hf0, 16'h000c);
        src_inv = 1'b0;
        src_lsb = 1'b0;
        send_id('0, 6);
        rb(8'hf4, 0, 1'b1);
        rb(8'hf4, 2, 1'b0);
        rb(8'hf6, 0, 1'b1);
        print_verdict();
    end
endmodule : test_trail_trace_receive
`default_nettype wire

// ==== testbench/ttrx_trace_src.sv ====
// Purpose: Serial trace source standing in for the receive framer.
// Assumes: One bit per cycle, or one per two cycles when slow is set.
// Notes:   Between bits the line toggles, so a stale bit never looks valid.
`timescale 1ns/1ns
`default_nettype none
module ttrx_trace_src (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] byte_in,
    input  wire logic       go,
    input  wire logic       lsb_first,
    input  wire logic       invert,
    input  wire logic       slow,
    output logic            busy,
    output logic            trace_bit,
    output logic            trace_bit_valid,
    output logic            trace_byte_start
);
    logic [7:0] sh_reg;
    logic [3:0] cnt_reg;
    logic       gap_reg;
    assign busy = (cnt_reg != 4'h0);
    always_ff @(posedge clk) begin
        trace_bit_valid  <= 1'b0;
        trace_byte_start <= 1'b0;
        trace_bit        <= ~trace_bit;
        gap_reg          <= 1'b0;
        if (!rst_n) begin
            cnt_reg   <= 4'h0;
            trace_bit <= 1'b0;
        end else if (go && !busy) begin
            sh_reg  <= invert ? ~byte_in : byte_in;
            cnt_reg <= 4'h8;
        end else if (busy && slow && !gap_reg) begin
            gap_reg <= 1'b1;
        end else if (busy) begin
            trace_bit        <= lsb_first ? sh_reg[0] : sh_reg[7];
            trace_bit_valid  <= 1'b1;
            trace_byte_start <= (cnt_reg == 4'h8);
            sh_reg           <= lsb_first ? sh_reg >> 1 : sh_reg << 1;
            cnt_reg          <= cnt_reg - 4'h1;
        end
    end
endmodule : ttrx_trace_src
`default_nettype wire
